// ===== common/sram_host_pkg.sv
package sram_host_pkg;
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam int CLK_PS = 25000;
  // device timing, picoseconds, fastest grade
  localparam int ACCESS_PS          = 10000;
  localparam int OE_ACCESS_PS       = 5000;
  localparam int oe_release_time    = 5000;
  localparam int select_drive_time  = 3000;
  localparam int oe_drive_time      = 0;
  localparam int read_hold_time     = 3000;
  localparam int WRITE_PULSE_OE_PS  = 10000;
  localparam int data_setup_time    = 5000;
  localparam int data_hold_time     = 0;
  localparam int CYCLE_PS           = 10000;
  function automatic int cyc_up(input int ps);
    int c;
    c = (ps + CLK_PS - 1) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction
  // cycle counts, least times rounded up
  localparam int RD_CYC   = cyc_up(ACCESS_PS) + 1; // +1 for pin sync
  localparam int WR_CYC   = cyc_up(WRITE_PULSE_OE_PS);
  localparam int TURN_CYC = cyc_up(oe_release_time);
  localparam int CNT_W    = 4;
  localparam logic [DATA_W-1:0] DATA_RST = 8'H00;
endpackage

// ===== common/sram_pins_if.sv
// pin-level bundle between sequencer and pin stage
interface sram_pins_if;
  import sram_host_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic              sel_n;
  logic              wr_n;
  logic              oe_n;
  logic [DATA_W-1:0] wdata;
  logic              drive;
  logic [DATA_W-1:0] rdata;
  modport seq (output addr, sel_n, wr_n, oe_n, wdata, drive, input rdata);
  modport pins (input addr, sel_n, wr_n, oe_n, wdata, drive, output rdata);
endinterface

// ===== logic/sram_pin_stage.sv
module sram_pin_stage (
  // clock and reset
  input  wire logic                             REF_CLK,
  input  wire logic                             RESET,
  // sequencer side
  sram_pins_if.pins                             p,
  // data pin input from the memory
  input  wire logic [sram_host_pkg::DATA_W-1:0] data_in,
  // synchronised read data, two flops
  output logic [sram_host_pkg::DATA_W-1:0]      data_sync
);
  import sram_host_pkg::*;
  logic [DATA_W-1:0] meta_reg;
  // pin data is asynchronous to REF_CLK, second flop is the only reader
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      meta_reg  <= DATA_RST;
      data_sync <= DATA_RST;
    end else begin
      meta_reg  <= data_in;
      data_sync <= meta_reg;
    end
  end
  assign p.rdata = data_sync;
endmodule

// ===== logic/sram_host_ctrl.sv
module sram_host_ctrl (
  // clock and reset
  input  wire logic                             REF_CLK,
  input  wire logic                             RESET,
  // user request port
  input  wire logic                             REQ_VALID,
  input  wire logic                             REQ_WRITE,
  input  wire logic [sram_host_pkg::ADDR_W-1:0] REQ_ADDR,
  input  wire logic [sram_host_pkg::DATA_W-1:0] REQ_WDATA,
  output logic                                  REQ_READY,
  output logic                                  RD_VALID,
  output logic [sram_host_pkg::DATA_W-1:0]      RD_DATA,
  // memory pins
  output logic [sram_host_pkg::ADDR_W-1:0]      ADDR_IN,
  output logic                                  SEL_N,
  output logic                                  WR_N,
  output logic                                  OE_N,
  input  wire logic [sram_host_pkg::DATA_W-1:0] DATA_IO_I,
  output logic [sram_host_pkg::DATA_W-1:0]      DATA_IO_O,
  output logic                                  DATA_IO_OE
);
  import sram_host_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'H0,
    ST_RD   = 3'H1,
    ST_RDON = 3'H3,
    ST_TURN = 3'H2,
    ST_WSET = 3'H6,
    ST_WR   = 3'H7,
    ST_WEND = 3'H5
  } state_e;

  state_e            state_reg;
  logic [CNT_W-1:0]  cnt_reg;
  logic [DATA_W-1:0] data_sync;

  sram_pins_if pif ();

  sram_pin_stage u_pins (
    .REF_CLK   (REF_CLK),
    .RESET     (RESET),
    .p         (pif.pins),
    .data_in   (DATA_IO_I),
    .data_sync (data_sync)
  );

  // mirror pin flops into the bundle for the pin stage
  assign pif.addr  = ADDR_IN;
  assign pif.sel_n = SEL_N;
  assign pif.wr_n  = WR_N;
  assign pif.oe_n  = OE_N;
  assign pif.wdata = DATA_IO_O;
  assign pif.drive = DATA_IO_OE;

  // sequencer: each phase lasts a whole number of 25 ns cycles, which
  // overshoots every least time; simpler than sub-cycle edge placement
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      state_reg  <= ST_IDLE;
      cnt_reg    <= '0;
      REQ_READY  <= 1'b0;
      RD_VALID   <= 1'b0;
      RD_DATA    <= DATA_RST;
      ADDR_IN    <= '0;
      SEL_N      <= 1'b1;
      WR_N       <= 1'b1;
      OE_N       <= 1'b1;
      DATA_IO_O  <= DATA_RST;
      DATA_IO_OE <= 1'b0;
    end else begin
      RD_VALID <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          REQ_READY <= 1'b1;
          if (REQ_VALID && REQ_READY) begin
            REQ_READY <= 1'b0;
            ADDR_IN   <= REQ_ADDR;
            SEL_N     <= 1'b0;
            cnt_reg   <= '0;
            if (REQ_WRITE) begin
              OE_N       <= 1'b1;
              DATA_IO_O  <= REQ_WDATA;
              DATA_IO_OE <= 1'b1;
              state_reg  <= ST_WSET;
            end else begin
              WR_N      <= 1'b1;
              OE_N      <= 1'b0;
              state_reg <= ST_RD;
            end
          end
        end
        ST_RD: begin
          // wait access plus two sync flops before sampling
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == CNT_W'(RD_CYC)) begin
            RD_DATA   <= data_sync;
            RD_VALID  <= 1'b1;
            state_reg <= ST_RDON;
          end
        end
        ST_RDON: begin
          SEL_N     <= 1'b1;
          OE_N      <= 1'b1;
          cnt_reg   <= '0;
          state_reg <= ST_TURN;
        end
        ST_TURN: begin
          // let device float before anyone drives again
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == CNT_W'(TURN_CYC - 1)) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_WSET: begin
          WR_N      <= 1'b0;
          cnt_reg   <= '0;
          state_reg <= ST_WR;
        end
        ST_WR: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == CNT_W'(WR_CYC - 1)) begin
            WR_N      <= 1'b1;
            state_reg <= ST_WEND;
          end
        end
        ST_WEND: begin
          // address, data and select held one cycle past write end
          SEL_N      <= 1'b1;
          DATA_IO_OE <= 1'b0;
          cnt_reg    <= '0;
          state_reg  <= ST_TURN;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // host never drives data while device may be in read mode
  a_no_contention: assert property (
    @(posedge REF_CLK) disable iff (RESET)
    !(DATA_IO_OE && !OE_N && WR_N && !SEL_N))
    else $error("host drives data during read mode");

  a_read_wr_high: assert property (
    @(posedge REF_CLK) disable iff (RESET)
    (!OE_N && !SEL_N) |-> WR_N)
    else $error("write strobe active during read");

  a_oe_no_drive: assert property (
    @(posedge REF_CLK) disable iff (RESET)
    !OE_N |-> !DATA_IO_OE)
    else $error("host drives data while output enabled");

  a_ready_idle: assert property (
    @(posedge REF_CLK) disable iff (RESET)
    REQ_READY |-> SEL_N && WR_N && OE_N && !DATA_IO_OE)
    else $error("ready raised while a cycle is open");

  // read path: enable edge, two sync flops, then the capture cycle
  a_read_sample: assert property (
    @(posedge REF_CLK) disable iff (RESET)
    $fell(OE_N) |-> ##3 RD_VALID)
    else $error("read sampled at wrong time");

  a_read_open: assert property (
    @(posedge REF_CLK) disable iff (RESET)
    RD_VALID |-> !OE_N && !SEL_N && WR_N)
    else $error("read data taken after the read closed");

  // write path: one whole cycle of strobe covers every least time
  a_write_pulse: assert property (
    @(posedge REF_CLK) disable iff (RESET)
    $fell(WR_N) |-> (!WR_N && !SEL_N)[*1] ##1 (WR_N && !SEL_N))
    else $error("write pulse length wrong");

  a_write_sel_first: assert property (
    @(posedge REF_CLK) disable iff (RESET)
    $fell(WR_N) |-> !$past(SEL_N))
    else $error("select not active before write start");

  a_write_select: assert property (
    @(posedge REF_CLK) disable iff (RESET)
    $rose(WR_N) |-> !SEL_N && DATA_IO_OE && $stable(ADDR_IN))
    else $error("select or data dropped before write end");

  a_addr_hold: assert property (
    @(posedge REF_CLK) disable iff (RESET)
    !WR_N |=> $stable(ADDR_IN))
    else $error("address moved during write");

  a_sel_addr_hold: assert property (
    @(posedge REF_CLK) disable iff (RESET)
    (!SEL_N && !$past(SEL_N)) |-> $stable(ADDR_IN))
    else $error("address moved while selected");

  a_data_setup: assert property (
    @(posedge REF_CLK) disable iff (RESET)
    $fell(WR_N) |-> $past(DATA_IO_OE) && $stable(DATA_IO_O))
    else $error("write data not set up");

  a_data_hold: assert property (
    @(posedge REF_CLK) disable iff (RESET)
    !WR_N |=> DATA_IO_OE && $stable(DATA_IO_O))
    else $error("write data released at write end");

  a_write_oe_off: assert property (
    @(posedge REF_CLK) disable iff (RESET)
    !WR_N |-> OE_N)
    else $error("output enable active during write");

  a_addr_at_end: assert property (
    @(posedge REF_CLK) disable iff (RESET)
    $rose(SEL_N) |-> $stable(ADDR_IN))
    else $error("address moved as select rose");

  a_turnaround: assert property (
    @(posedge REF_CLK) disable iff (RESET)
    $rose(SEL_N) |=> SEL_N)
    else $error("cycles not spaced");

  a_idle_gap: assert property (
    @(posedge REF_CLK) disable iff (RESET)
    $rose(SEL_N) |-> SEL_N[*3])
    else $error("idle gap between cycles too short");
endmodule

// ===== tb/sram_model_beh.sv
module sram_model_beh
  import sram_host_pkg::*;
(
  // host strobes
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic              sel_n,
  input  wire logic              wr_n,
  input  wire logic              oe_n,
  // data lines
  input  wire logic [DATA_W-1:0] din,
  output logic [DATA_W-1:0]      dout,
  output logic                   drive
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1]; // every byte, no refresh
  logic              writing;
  logic              reading;
  // mode decode, a late select never drives
  assign writing = !sel_n && !wr_n;
  assign reading = !sel_n && wr_n && !oe_n;
  // store at end of overlap, zero hold
  always @(negedge writing) mem[addr_in] = din;
  // old value kept 3 ns, then junk until full access time
  always @(addr_in or reading) begin
    dout <= #3 ~dout;
    if (reading) dout <= #10 mem[addr_in];
  end
  // enable alone is quicker than an address access
  always @(negedge oe_n) begin
    if (!sel_n && wr_n) dout <= #5 mem[addr_in];
  end
  // drive 3 ns after read starts, release 5 ns after it ends
  always @(reading) begin
    if (reading) drive <= #3 1'b1;
    else drive <= #5 1'b0;
  end
  initial begin
    dout = 8'H5A;
    drive = 1'b0;
  end
endmodule

// ===== tb/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import sram_host_pkg::*;
  logic ref_clk = 1'b0, reset = 1'b1;
  logic req_valid = 1'b0, req_write = 1'b0;
  logic [ADDR_W-1:0] req_addr = 19'H0, addr_in, prev_addr;
  logic [DATA_W-1:0] req_wdata = 8'H0, rd_data, dout, dio_o, bus;
  logic [DATA_W-1:0] float_pat = 8'H3C, prev_dio;
  logic req_ready, rd_valid, sel_n, wr_n, oe_n, dio_oe, drive;
  logic prev_sel_n = 1'b1, prev_wr_n = 1'b1;
  int n_errors = 0, checked = 0;
  // undriven lines wander, so stale data cannot pass
  assign bus = dio_oe ? dio_o : drive ? dout : float_pat;
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) float_pat <= ~float_pat + 8'H1;
  sram_host_ctrl i_sram_host_ctrl (.REF_CLK(ref_clk), .RESET(reset),
    .REQ_VALID(req_valid), .REQ_WRITE(req_write), .REQ_ADDR(req_addr),
    .REQ_WDATA(req_wdata), .REQ_READY(req_ready), .RD_VALID(rd_valid),
    .RD_DATA(rd_data), .ADDR_IN(addr_in), .SEL_N(sel_n), .WR_N(wr_n),
    .OE_N(oe_n), .DATA_IO_I(bus), .DATA_IO_O(dio_o),
    .DATA_IO_OE(dio_oe));
  sram_model_beh i_mem (.addr_in(addr_in), .sel_n(sel_n), .wr_n(wr_n),
    .oe_n(oe_n), .din(dio_o), .dout(dout), .drive(drive));
  task automatic chk(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic conclude();
    if (n_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // one request, waits for ready under a bound
  task automatic access(input logic w, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    #2;
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    while (req_ready !== 1'b1 && n < 40) begin
      @(posedge ref_clk);
      #2;
      n++;
    end
    chk("ready wait", n < 40, 1);
    @(posedge ref_clk);
    #2;
    req_valid = 1'b0;
  endtask
  // read: answer exactly at c3, ready again at c6
  task automatic t_read(input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] e);
    access(1'b0, a, 8'H0);
    repeat (2) @(posedge ref_clk);
    #2;
    chk("early valid", rd_valid, 0);
    @(posedge ref_clk);
    #2;
    chk("rd valid", rd_valid, 1);
    chk("rd data", rd_data, e);
    @(posedge ref_clk);
    #2;
    chk("valid pulse", rd_valid, 0);
    chk("data stands", rd_data, e);
    @(posedge ref_clk);
    #2;
    chk("ready low", req_ready, 0);
    @(posedge ref_clk);
    #2;
    chk("ready back", req_ready, 1);
  endtask
  // pin discipline seen every cycle
  always @(posedge ref_clk) begin
    if (!reset) begin
      chk("contend", dio_oe && drive, 0);
      if (!oe_n) chk("wr in read", {wr_n, dio_oe}, 2'H2);
      if (!wr_n) chk("wr strobes", {sel_n, oe_n, dio_oe}, 3'H3);
      if (!sel_n && !prev_sel_n) chk("addr hold", addr_in, prev_addr);
      if (!wr_n && !prev_wr_n) chk("wdata hold", dio_o, prev_dio);
    end
    prev_sel_n = sel_n;
    prev_wr_n = wr_n;
    prev_addr = addr_in;
    prev_dio = dio_o;
  end
  initial begin
    #20000;
    n_errors++;
    conclude();
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    #2;
    chk("rst pins", {sel_n, wr_n, oe_n, dio_oe, req_ready}, 5'H1C);
    reset = 1'b0;
    // corner addresses, then overwrite, then back-to-back reads
    access(1'b1, 19'H00000, 8'HA5);
    access(1'b1, 19'H7FFFF, 8'H3C);
    access(1'b1, 19'H2AAAA, 8'HFF);
    t_read(19'H7FFFF, 8'H3C);
    access(1'b1, 19'H7FFFF, 8'H00);
    t_read(19'H7FFFF, 8'H00);
    t_read(19'H00000, 8'HA5);
    t_read(19'H2AAAA, 8'HFF);
    conclude();
  end
endmodule
